// ---- design/ccr_clock_ratio.sv ----
// Clock ratio register, enable generation and frequency-change sequencer
`timescale 1ns/10ps
module ccr_clock_ratio
	import ccr_pkg::*;
#(
	parameter int SETTLE_W = 8
) (
	input  wire logic         clock,
	input  wire logic         resetn,
	input  wire logic         internalResetn,
	input  wire logic [2:0]   clockMode,
	input  wire logic         prescaleTick,
	input  wire logic [31:0]  s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [31:0]  s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	output logic              coreClkEn,
	output logic              busClkEn,
	output logic              periphClkEn,
	output logic              busClockPinEn,
	output logic              busClockPinOe,
	output logic              clocksStalled,
	output logic              illegalCode
);
	logic [7:0]   freqSel_q;
	logic         captured_q;
	ccr_state_e   state_q;
	logic [2:0]   coreExp_q;
	logic [2:0]   busExp_q;
	logic [2:0]   perExp_q;
	logic [2:0]   pinExp_q;
	logic         awHeld_q;
	logic         wHeld_q;
	logic [31:0]  awAddr_q;
	logic [31:0]  wData_q;
	logic [3:0]   wStrb_q;
	logic         awReady_q;
	logic         wReady_q;
	logic         bValid_q;
	logic [1:0]   bResp_q;
	logic         arReady_q;
	logic         rValid_q;
	logic [31:0]  rData_q;
	logic [1:0]   rResp_q;
	logic         coreEn_q;
	logic         busEn_q;
	logic         perEn_q;
	logic         pinEn_q;
	logic         pinOe_q;
	logic         illegal_q;
	logic         stalled_q;

	// Mode decode and forced bits
	wire        pinInputMode = clockMode[2];
	wire        force2       = clockMode[2];
	wire        force1       = (clockMode == 3'h2) || (clockMode == 3'h3)
	                           || (clockMode == 3'h6);
	wire        forcePin     = clockMode[2];
	wire [7:0]  forceMask    = {force2, force1, forcePin, 5'h00};
	wire [7:0]  readValue    = (freqSel_q & 8'hef) | forceMask;
	wire        secondByp    = readValue[SECOND_BYP_BIT];
	wire        firstByp     = readValue[FIRST_BYP_BIT];
	wire [3:0]  code         = readValue[3:0];

	// Reset value from mode pins
	wire [7:0]  modeReset =
		(clockMode == 3'h2) ? RESET_MODE2 :
		(clockMode == 3'h3) ? RESET_MODE3 :
		(clockMode == 3'h6) ? RESET_MODE6 :
		pinInputMode        ? RESET_MODE45 : RESET_MODE01;

	// Ratio tables as exponents relative to an x4 reference (x4=0, x1=2, x1/4=4)
	logic [2:0] tCore;
	logic [2:0] tBus;
	logic [2:0] tPer;
	logic [2:0] tPin;
	logic       tOk;
	always_comb begin
		tCore = DIV4;
		tBus  = DIV4;
		tPer  = DIV4;
		tPin  = DIV4;
		tOk   = 1'b0;
		if (!firstByp && !secondByp) begin
			tOk = 1'b1;
			case (code)
				4'h0: begin tCore = DIV4; tBus = DIV4; tPer = DIV4; end
				4'h4: begin tCore = DIV2; tBus = DIV4; tPer = DIV4; end
				4'h5: begin tCore = DIV2; tBus = DIV2; tPer = DIV4; end
				4'h6: begin tCore = DIV2; tBus = DIV2; tPer = DIV2; end
				4'h8: begin tCore = DIV1; tBus = DIV4; tPer = DIV4; end
				4'h9: begin tCore = DIV1; tBus = DIV2; tPer = DIV4; end
				4'ha: begin tCore = DIV1; tBus = DIV2; tPer = DIV2; end
				4'hc: begin tCore = DIV1; tBus = DIV1; tPer = DIV4; end
				4'he: begin tCore = DIV1; tBus = DIV1; tPer = DIV2; end
				default: tOk = 1'b0;
			endcase
			tPin = tBus;
		end else if (firstByp && !secondByp) begin
			tOk = 1'b1;
			case (code)
				4'h0: begin tCore = DIV4; tBus = DIV4; tPer = DIV4; end
				4'h5: begin tCore = DIV2; tBus = DIV2; tPer = DIV4; end
				4'h6: begin tCore = DIV2; tBus = DIV2; tPer = DIV2; end
				4'hc: begin tCore = DIV1; tBus = DIV1; tPer = DIV4; end
				4'he: begin tCore = DIV1; tBus = DIV1; tPer = DIV2; end
				default: tOk = 1'b0;
			endcase
			tPin = tBus;
		end else if (!firstByp && !pinInputMode) begin
			tOk = 1'b1;
			case (code)
				4'h0: begin tCore = DIV4; tBus = DIV4; tPer = DIV4; end
				4'h4: begin tCore = DIV2; tBus = DIV4; tPer = DIV4; end
				4'h8: begin tCore = DIV1; tBus = DIV4; tPer = DIV4; end
				default: tOk = 1'b0;
			endcase
			tPin = tBus;
		end else if (!firstByp) begin
			tOk = 1'b1;
			case (code)
				4'h5: begin tCore = DIV4; tBus = DIV4; tPer = DIV8; end
				4'h6: begin tCore = DIV4; tBus = DIV4; tPer = DIV4; end
				4'h9: begin tCore = DIV2; tBus = DIV4; tPer = DIV8; end
				4'ha: begin tCore = DIV2; tBus = DIV4; tPer = DIV4; end
				default: tOk = 1'b0;
			endcase
			tPin = tBus;
		end else begin
			tOk  = 1'b1;
			tPin = DIV4;
			case (code)
				4'h0: begin tCore = DIV16; tBus = DIV16; tPer = DIV16; end
				4'h4: begin tCore = DIV8; tBus = DIV16; tPer = DIV16; end
				4'h5: begin tCore = DIV8; tBus = DIV8; tPer = DIV16; end
				4'h6: begin tCore = DIV8; tBus = DIV8; tPer = DIV8; end
				4'h8: begin tCore = DIV4; tBus = DIV16; tPer = DIV16; end
				4'h9: begin tCore = DIV4; tBus = DIV8; tPer = DIV16; end
				4'ha: begin tCore = DIV4; tBus = DIV8; tPer = DIV8; end
				4'hc: begin tCore = DIV4; tBus = DIV4; tPer = DIV16; end
				4'he: begin tCore = DIV4; tBus = DIV4; tPer = DIV8; end
				4'hf: begin tCore = DIV4; tBus = DIV4; tPer = DIV4; end
				default: tOk = 1'b0;
			endcase
		end
	end

	// AXI write path: address and data taken in either order
	wire        wrFire    = awHeld_q && wHeld_q && !bValid_q;
	wire        wrHit     = (awAddr_q[31:2] == FREQ_SEL_ADDR[31:2]);
	wire        wrLane0   = wStrb_q[0];
	wire [7:0]  wrValue   = wData_q[7:0] & 8'hef;
	wire [7:0]  wrEff     = (wrValue & ~forceMask) | forceMask;
	wire        running   = (state_q == CcrRun);
	wire        changes   = (wrEff[7:6] != readValue[7:6])
	                        || (wrEff[3:0] != readValue[3:0]);
	wire        changeReq = wrFire && wrHit && wrLane0 && running && changes;
	wire        rdHit     = (s_axi_araddr[31:2] == FREQ_SEL_ADDR[31:2]);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			awHeld_q  <= 1'b0;
			wHeld_q   <= 1'b0;
			awAddr_q  <= '0;
			wData_q   <= '0;
			wStrb_q   <= '0;
			awReady_q <= 1'b0;
			wReady_q  <= 1'b0;
			bValid_q  <= 1'b0;
			bResp_q   <= AXI_OKAY;
		end else begin
			awReady_q <= !awHeld_q && !(s_axi_awvalid && awReady_q) && !bValid_q;
			wReady_q  <= !wHeld_q && !(s_axi_wvalid && wReady_q) && !bValid_q;
			if (s_axi_awvalid && awReady_q) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && wReady_q) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (wrFire) begin
				awHeld_q <= 1'b0;
				wHeld_q  <= 1'b0;
				bValid_q <= 1'b1;
				bResp_q  <= wrHit ? AXI_OKAY : AXI_SLVERR;
			end else if (bValid_q && s_axi_bready) begin
				bValid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			arReady_q <= 1'b0;
			rValid_q  <= 1'b0;
			rData_q   <= '0;
			rResp_q   <= AXI_OKAY;
		end else begin
			arReady_q <= !rValid_q && !(s_axi_arvalid && arReady_q);
			if (s_axi_arvalid && arReady_q) begin
				rValid_q <= 1'b1;
				rData_q  <= rdHit ? {24'h000000, readValue} : 32'h00000000;
				rResp_q  <= rdHit ? AXI_OKAY : AXI_SLVERR;
			end else if (rValid_q && s_axi_rready) begin
				rValid_q <= 1'b0;
			end
		end
	end

	// Register holds through watchdog resets; captured once after power-on release
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			freqSel_q  <= 8'h00;
			captured_q <= 1'b0;
		end else if (!captured_q) begin
			freqSel_q  <= modeReset;
			captured_q <= 1'b1;
		// Ratio or bypass writes mid-stall are dropped: the settle in flight covers the old target
		end else if (wrFire && wrHit && wrLane0 && (running || !changes)) begin
			freqSel_q  <= wrEff;
		end
	end

	// Stall sequencer; overflow here is private, it touches no watchdog flag
	wire settleOvf;
	ccr_settle_counter #(
		.W (SETTLE_W)
	) u_settle (
		.clock    (clock),
		.resetn   (resetn),
		.start    (changeReq),
		.countEn  (prescaleTick),
		.overflow (settleOvf)
	);

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			state_q <= CcrRun;
		else begin
			case (state_q)
				CcrRun:    if (changeReq) state_q <= CcrStall;
				CcrStall:  state_q <= CcrSettle;
				CcrSettle: if (settleOvf) state_q <= CcrRun;
				default:   state_q <= CcrRun;
			endcase
		end
	end

	// Tracks the next state so the stall output leaves from a flop
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			stalled_q <= 1'b0;
		else
			stalled_q <= changeReq || (state_q == CcrStall)
			             || ((state_q == CcrSettle) && !settleOvf);
	end

	// Exponents latched only while running so new ratios appear after overflow
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			coreExp_q <= DIV4;
			busExp_q  <= DIV4;
			perExp_q  <= DIV4;
			pinExp_q  <= DIV4;
			illegal_q <= 1'b0;
		end else if (running && !changeReq && internalResetn) begin
			coreExp_q <= tCore;
			busExp_q  <= tBus;
			perExp_q  <= tPer;
			pinExp_q  <= tPin;
			illegal_q <= !tOk;
		end
	end

	wire [2:0] expSel [4];
	wire       tickSel [4];
	assign expSel[0] = coreExp_q;
	assign expSel[1] = busExp_q;
	assign expSel[2] = perExp_q;
	assign expSel[3] = pinExp_q;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_div
			ccr_divider u_div (
				.clock  (clock),
				.resetn (resetn),
				.run    (running),
				.expIn  (expSel[g]),
				.tick   (tickSel[g])
			);
		end
	endgenerate

	// Pin output: bus clock when any PLL runs, else raw input; pin released when input
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			coreEn_q <= 1'b0;
			busEn_q  <= 1'b0;
			perEn_q  <= 1'b0;
			pinEn_q  <= 1'b0;
			pinOe_q  <= 1'b1;
		end else begin
			coreEn_q <= tickSel[0];
			busEn_q  <= tickSel[1];
			perEn_q  <= tickSel[2];
			pinEn_q  <= (!firstByp || !secondByp) ? tickSel[1] : tickSel[3];
			pinOe_q  <= readValue[PIN_HIZ_BIT];
		end
	end

	assign s_axi_awready = awReady_q;
	assign s_axi_wready  = wReady_q;
	assign s_axi_bvalid  = bValid_q;
	assign s_axi_bresp   = bResp_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rvalid  = rValid_q;
	assign s_axi_rdata   = rData_q;
	assign s_axi_rresp   = rResp_q;
	assign coreClkEn     = coreEn_q;
	assign busClkEn      = busEn_q;
	assign periphClkEn   = perEn_q;
	assign busClockPinEn = pinEn_q;
	assign busClockPinOe = pinOe_q;
	assign clocksStalled = stalled_q;
	assign illegalCode   = illegal_q;
endmodule // ccr_clock_ratio

// ---- design/ccr_divider.sv ----
// Free-running power-of-two divider giving one-cycle enable pulses per exponent
`timescale 1ns/10ps
module ccr_divider
	import ccr_pkg::*;
#(
	parameter int W = DIV_W
) (
	input  wire logic         clock,
	input  wire logic         resetn,
	input  wire logic         run,
	input  wire logic [2:0]   expIn,
	output logic              tick
);
	logic [W-1:0] count_q;
	logic [W-1:0] mask;
	assign mask = W'((1 << expIn) - 1);

	// Held at zero while stopped so clocks restart phase-aligned
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			count_q <= '0;
		else if (!run)
			count_q <= '0;
		else
			count_q <= count_q + 1'b1;
	end

	assign tick = run && ((count_q & mask) == '0);
endmodule // ccr_divider

// ---- design/ccr_pkg.sv ----
// Package: register map, field layout, reset values and divider exponents for the clock ratio block
package ccr_pkg;
	localparam logic [31:0] FREQ_SEL_ADDR   = 32'hfffffe90;
	localparam int          SECOND_BYP_BIT  = 7;
	localparam int          FIRST_BYP_BIT   = 6;
	localparam int          PIN_HIZ_BIT     = 5;
	localparam int          RESERVED_BIT    = 4;
	localparam logic [7:0]  RESET_MODE01    = 8'h00;
	localparam logic [7:0]  RESET_MODE2     = 8'h40;
	localparam logic [7:0]  RESET_MODE3     = 8'h60;
	localparam logic [7:0]  RESET_MODE45    = 8'ha6;
	localparam logic [7:0]  RESET_MODE6     = 8'he0;
	localparam logic [1:0]  AXI_OKAY        = 2'h0;
	localparam logic [1:0]  AXI_SLVERR      = 2'h2;
	// Divider exponents: clock = base >> exponent, base is input x4 (one step = /2)
	localparam logic [2:0]  DIV1 = 3'h0;
	localparam logic [2:0]  DIV2 = 3'h1;
	localparam logic [2:0]  DIV4 = 3'h2;
	localparam logic [2:0]  DIV8 = 3'h3;
	localparam logic [2:0]  DIV16 = 3'h4;
	localparam int          DIV_W = 5;
	typedef enum logic [1:0] {CcrRun, CcrStall, CcrSettle} ccr_state_e;
endpackage

// ---- design/ccr_settle_counter.sv ----
// Settling counter standing in for the watchdog count during a frequency change
`timescale 1ns/10ps
module ccr_settle_counter #(
	parameter int W = 8
) (
	input  wire logic         clock,
	input  wire logic         resetn,
	input  wire logic         start,
	input  wire logic         countEn,
	output logic              overflow
);
	logic [W-1:0] count_q;
	logic         busy_q;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			count_q <= '0;
			busy_q  <= 1'b0;
		end else if (start) begin
			count_q <= '0;
			busy_q  <= 1'b1;
		end else if (busy_q && countEn) begin
			count_q <= count_q + 1'b1;
			if (&count_q)
				busy_q <= 1'b0;
		end
	end

	assign overflow = busy_q && countEn && (&count_q);
endmodule // ccr_settle_counter

// ---- sim/ccr_clock_ratio_asserts.sv ----
// Checker: bus answers, forced bits and change sequencing of the clock ratio block
`timescale 1ns/10ps
module ccr_clock_ratio_asserts
	import ccr_pkg::*;
#(
	parameter int SETTLE_W = 8
) (
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic [2:0]  clockMode,
	input wire logic        prescaleTick,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [31:0] s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        coreClkEn,
	input wire logic        busClkEn,
	input wire logic        periphClkEn,
	input wire logic        clocksStalled
);
	localparam int SETTLE_N = 2 ** SETTLE_W;
	logic [9:0]    tickCnt_q;
	wire           arTake = s_axi_arvalid && s_axi_arready;
	wire           regHit = s_axi_araddr[31:2] == FREQ_SEL_ADDR[31:2];

	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	// Ticks seen during the current stall; cleared while running
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			tickCnt_q <= '0;
		else if (!clocksStalled)
			tickCnt_q <= '0;
		else if (prescaleTick)
			tickCnt_q <= tickCnt_q + 10'h1;
	end

	a_stall_quiet: assert property (clocksStalled && $past(clocksStalled) |->
		!(coreClkEn || busClkEn || periphClkEn)) else $error("enable pulse during stall");
	a_stall_cause: assert property ($rose(clocksStalled) |->
		$past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3)) else $error("stall without write");
	a_settle_bound: assert property ($rose(clocksStalled) |-> ##[1:400] !clocksStalled)
		else $error("stall never ends");
	a_settle_ticks: assert property ($fell(clocksStalled) |->
		tickCnt_q >= SETTLE_N - 1 && tickCnt_q <= SETTLE_N + 1) else $error("settle count off");
	a_read_unmapped: assert property (arTake && !regHit |=>
		s_axi_rvalid && s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read answer wrong");
	a_read_reg: assert property (arTake && regHit |=>
		s_axi_rvalid && s_axi_rresp == AXI_OKAY && s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[4])
		else $error("register read answer wrong");
	a_second_forced: assert property (arTake && regHit && clockMode >= 3'h4 |=>
		s_axi_rdata[7]) else $error("bit 7 not forced");
	a_first_forced: assert property (arTake && regHit && clockMode inside {3'h2, 3'h3, 3'h6}
		|=> s_axi_rdata[6]) else $error("bit 6 not forced");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
endmodule // ccr_clock_ratio_asserts

bind ccr_clock_ratio ccr_clock_ratio_asserts #(
	.SETTLE_W (SETTLE_W)
) u_chk (
	.clock         (clock),
	.resetn        (resetn),
	.clockMode     (clockMode),
	.prescaleTick  (prescaleTick),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_araddr  (s_axi_araddr),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rdata   (s_axi_rdata),
	.s_axi_rresp   (s_axi_rresp),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready),
	.coreClkEn     (coreClkEn),
	.busClkEn      (busClkEn),
	.periphClkEn   (periphClkEn),
	.clocksStalled (clocksStalled)
);

// ---- sim/tb_ccr_clock_ratio.sv ----
// Testbench: register access, ratio tables and change sequencing of the clock ratio block
`timescale 1ns/10ps
module tb_ccr_clock_ratio
	import ccr_pkg::*;
;
	logic        clock, resetn, internalResetn, prescaleTick;
	logic [2:0]  clockMode;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, ph;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic        coreClkEn, busClkEn, periphClkEn, busClockPinEn, busClockPinOe;
	logic        clocksStalled, illegalCode;
	logic [31:0] rd;
	int          fail_count, n_compared;
	// Write byte, then period exponents of core, bus, peripheral, pin
	logic [23:0] tbl [6] = '{24'h08_0222, 24'h45_1121, 24'h84_1222,
		24'hc0_4442, 24'h00_2222, 24'h0e_0010};

	ccr_clock_ratio #(
		.SETTLE_W (3)
	) DUT (
		.clock          (clock),
		.resetn         (resetn),
		.internalResetn (internalResetn),
		.clockMode      (clockMode),
		.prescaleTick   (prescaleTick),
		.s_axi_awaddr   (s_axi_awaddr),
		.s_axi_awvalid  (s_axi_awvalid),
		.s_axi_awready  (s_axi_awready),
		.s_axi_wdata    (s_axi_wdata),
		.s_axi_wstrb    (s_axi_wstrb),
		.s_axi_wvalid   (s_axi_wvalid),
		.s_axi_wready   (s_axi_wready),
		.s_axi_bresp    (s_axi_bresp),
		.s_axi_bvalid   (s_axi_bvalid),
		.s_axi_bready   (s_axi_bready),
		.s_axi_araddr   (s_axi_araddr),
		.s_axi_arvalid  (s_axi_arvalid),
		.s_axi_arready  (s_axi_arready),
		.s_axi_rdata    (s_axi_rdata),
		.s_axi_rresp    (s_axi_rresp),
		.s_axi_rvalid   (s_axi_rvalid),
		.s_axi_rready   (s_axi_rready),
		.coreClkEn      (coreClkEn),
		.busClkEn       (busClkEn),
		.periphClkEn    (periphClkEn),
		.busClockPinEn  (busClockPinEn),
		.busClockPinOe  (busClockPinOe),
		.clocksStalled  (clocksStalled),
		.illegalCode    (illegalCode)
	);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Slow oscillator tick, one in four clocks
	always @(posedge clock) begin
		ph <= ph + 4'h1;
		prescaleTick <= (ph[1:0] == 2'h3);
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic complete_run();
		if (fail_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic rst(input logic [2:0] m);
		clockMode <= m;
		resetn <= 1'b0;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
		repeat (2) @(posedge clock);
	endtask

	// Ready is raised late on purpose so the answer must stand
	task automatic axw(input logic [31:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		repeat (2) @(posedge clock);
		s_axi_bready <= 1'b1;
		do @(posedge clock); while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clock);
	endtask

	task automatic axr(input logic [31:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge clock); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		repeat (2) @(posedge clock);
		s_axi_rready <= 1'b1;
		do @(posedge clock); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask

	task automatic settle();
		repeat (2) @(posedge clock);
		while (clocksStalled) @(posedge clock);
		repeat (2) @(posedge clock);
	endtask

	// Clocks between two pulses of enable i: 0 core, 1 bus, 2 peripheral, 3 pin
	task automatic per(input int i, output logic [31:0] p);
		logic [3:0] v;
		do begin
			@(posedge clock);
			v = {busClockPinEn, periphClkEn, busClkEn, coreClkEn};
		end while (v[i] !== 1'b1);
		p = 32'h0;
		do begin
			@(posedge clock);
			p++;
			v = {busClockPinEn, periphClkEn, busClkEn, coreClkEn};
		end while (v[i] !== 1'b1);
	endtask

	task automatic chg(input logic [23:0] t);
		logic [31:0] p;
		axr(32'h26200000);
		axw(FREQ_SEL_ADDR, {24'h0, t[23:16]});
		chk({31'h0, clocksStalled}, 32'h1);
		settle();
		for (int i = 0; i < 4; i++) begin
			per(i, p);
			chk(p, 32'h1 << t[4 * (3 - i) +: 4]);
		end
		chk({31'h0, illegalCode}, 32'h0);
	endtask

	initial begin
		{ph, prescaleTick, clockMode, resetn} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		internalResetn = 1'b1;
		s_axi_wstrb = 4'hf;
		fail_count = 0;
		n_compared = 0;
		rst(3'h0);
		axr(FREQ_SEL_ADDR);
		chk(rd, 32'h0);
		chk({31'h0, busClockPinOe}, 32'h0);
		axr(FREQ_SEL_ADDR + 32'h4);
		chk({30'h0, rs}, {30'h0, AXI_SLVERR});
		chk(rd, 32'h0);
		axw(FREQ_SEL_ADDR + 32'h4, 32'hff);
		chk({30'h0, rs}, {30'h0, AXI_SLVERR});
		foreach (tbl[k])
			chg(tbl[k]);
		// A change written while stalled is dropped
		axw(FREQ_SEL_ADDR, 32'h08);
		axw(FREQ_SEL_ADDR, 32'h0e);
		chk({30'h0, rs}, {30'h0, AXI_OKAY});
		settle();
		internalResetn <= 1'b0;
		repeat (3) @(posedge clock);
		internalResetn <= 1'b1;
		repeat (2) @(posedge clock);
		axr(FREQ_SEL_ADDR);
		chk(rd, 32'h08);
		axw(FREQ_SEL_ADDR, 32'h03);
		settle();
		chk({31'h0, illegalCode}, 32'h1);
		rst(3'h4);
		axr(FREQ_SEL_ADDR);
		chk(rd, 32'ha6);
		chk({31'h0, busClockPinOe}, 32'h1);
		chg(24'h25_2232);
		axr(FREQ_SEL_ADDR);
		chk(rd, 32'ha5);
		rst(3'h6);
		axr(FREQ_SEL_ADDR);
		chk(rd, 32'he0);
		complete_run();
	end

	initial begin
		repeat (20000) @(posedge clock);
		fail_count++;
		complete_run();
	end
endmodule // tb_ccr_clock_ratio
